// ==== ssrv_consts.vh ====
// Constants for the speed setpoint, ramp and V/f select block
`ifndef SSRV_CONSTS_VH
`define SSRV_CONSTS_VH
// Register byte offsets
`define SSRV_OFF_CTRL 8'h00
`define SSRV_OFF_SETPOINT 8'h04
`define SSRV_OFF_MIN_SPEED 8'h08
`define SSRV_OFF_MAX_SPEED 8'h0C
`define SSRV_OFF_RAMP_UP 8'h10
`define SSRV_OFF_RAMP_DOWN 8'h14
`define SSRV_OFF_QSTOP 8'h18
`define SSRV_OFF_ROUNDING 8'h1C
`define SSRV_OFF_STATOR_R 8'h20
`define SSRV_OFF_SLIP_GAIN 8'h24
`define SSRV_OFF_RAMP_TOL 8'h28
`define SSRV_OFF_STATUS 8'h2C
`define SSRV_OFF_RAMP_OUT 8'h30
`define SSRV_OFF_FREQ 8'h34
`define SSRV_OFF_FMAX 8'h38
`define SSRV_OFF_VOLT 8'h3C
`define SSRV_OFF_VF_GAIN 8'h40
// Control field positions
`define SSRV_CTRL_RUN 0
`define SSRV_CTRL_QSTOP 1
`define SSRV_CTRL_EXT 2
`define SSRV_CTRL_MODE_LO 4
`define SSRV_CTRL_MODE_HI 6
`define SSRV_CTRL_PP_LO 8
`define SSRV_CTRL_PP_HI 15
// Status field positions
`define SSRV_ST_OVERSPEED 0
`define SSRV_ST_AT_TARGET 1
`define SSRV_ST_ECO 2
`define SSRV_ST_QSTOP 3
`define SSRV_ST_ILIM 4
`define SSRV_ST_SLIP_EN 5
// Reset values
`define SSRV_RST_CTRL 16'h0200
`define SSRV_RST_MIN_SPEED 16'h0000
`define SSRV_RST_MAX_SPEED 16'h05DC
`define SSRV_RST_RAMP 16'h2710
`define SSRV_RST_QSTOP 16'h2710
`define SSRV_RST_SLIP_GAIN 16'h0000
`define SSRV_RST_RAMP_TOL 16'h000A
`define SSRV_RST_VF_GAIN 16'h0100
// Timing: clock 10 MHz, control sample 1 ms, ramp durations in ms
`define SSRV_CLK_KHZ 10000
`define SSRV_SAMPLE_MS 1
`define SSRV_SAMPLE_CYCLES (`SSRV_SAMPLE_MS * `SSRV_CLK_KHZ)
`define SSRV_ECO_DELAY_MS 5000
`define SSRV_ECO_SAMPLES (`SSRV_ECO_DELAY_MS / `SSRV_SAMPLE_MS)
// Voltage scaling
`define SSRV_REL_SHIFT 10
`define SSRV_ECO_LEVEL 16'h00E6
`define SSRV_FCC_SHIFT 10
`define SSRV_TRIM_STEP 16'h0008
`endif

// ==== ssrv_div.v ====
// Sequential restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module ssrv_div #(
   parameter W = 32
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Request
   input wire start_i,
   input wire [W-1:0] dividend_i,
   input wire [W-1:0] divisor_i,
   // Answer
   output reg done_o,
   output reg [W-1:0] quot_o,
   output reg [W-1:0] rem_o
);
   reg [W-1:0] dvs_q;
   reg [6:0] cnt_q;
   reg busy_q;
   wire [W:0] trial = {rem_o, quot_o[W-1]} - {1'b0, dvs_q};

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy_q <= 1'b0;
         done_o <= 1'b0;
         cnt_q <= 7'h00;
         dvs_q <= {W{1'b0}};
         quot_o <= {W{1'b0}};
         rem_o <= {W{1'b0}};
      end
      else
      begin
         done_o <= 1'b0;
         if (start_i && !busy_q)
         begin
            busy_q <= 1'b1;
            cnt_q <= W[6:0];
            dvs_q <= divisor_i;
            quot_o <= dividend_i;
            rem_o <= {W{1'b0}};
         end
         else if (busy_q)
         begin
            // Zero divisor gives all ones; the caller never asks for it
            if (!trial[W])
            begin
               rem_o <= trial[W-1:0];
               quot_o <= {quot_o[W-2:0], 1'b1};
            end
            else
            begin
               rem_o <= {rem_o[W-2:0], quot_o[W-1]};
               quot_o <= {quot_o[W-2:0], 1'b0};
            end
            cnt_q <= cnt_q - 7'h01;
            if (cnt_q == 7'h01)
            begin
               busy_q <= 1'b0;
               done_o <= 1'b1;
            end
         end
      end
   end
endmodule // ssrv_div
`default_nettype wire

// ==== ssrv_top.v ====
// Speed setpoint clamp, ramp generator and V/f characteristic select
`timescale 1ns/1ps
`default_nettype none
`include "ssrv_consts.vh"
module ssrv_top #(
   parameter SAMPLE_CYCLES = `SSRV_SAMPLE_CYCLES,
   parameter ECO_SAMPLES = `SSRV_ECO_SAMPLES
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Drive feedback, same clock
   input wire [15:0] actual_speed_i,
   input wire [15:0] motor_current_i,
   input wire current_limit_i,
   input wire dc_link_high_i,
   input wire dc_link_low_i,
   // Modulation stage
   output reg [15:0] speed_ref_o,
   output reg [15:0] freq_o,
   output reg [15:0] volt_o,
   output reg slip_comp_en_o,
   output reg eco_active_o,
   output reg overspeed_o
);
   localparam S_IDLE = 2'd0;
   localparam S_STEP = 2'd1;
   localparam S_REL = 2'd2;

   function [15:0] merge16;
      input [15:0] old;
      input [15:0] nw;
      input [1:0] sel;
      begin
         merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
      end
   endfunction

   function [15:0] mag;
      input [15:0] v;
      begin
         mag = v[15] ? (16'h0000 - v) : v;
      end
   endfunction

   // Configuration registers
   reg [15:0] ctrl_q;
   reg [15:0] setpoint_q;
   reg [15:0] min_q;
   reg [15:0] max_q;
   reg [15:0] up_q;
   reg [15:0] down_q;
   reg [15:0] qstop_q;
   reg [15:0] rnd_init_q;
   reg [15:0] rnd_final_q;
   reg [15:0] stator_r_q;
   reg [15:0] slip_gain_q;
   reg [15:0] tol_q;
   reg [15:0] vf_gain_q;
   // Block state
   reg [1:0] state_q;
   reg [15:0] tick_cnt_q;
   reg [15:0] ramp_q;
   reg [16:0] frac_q;
   reg [16:0] dur_q;
   reg [15:0] fmax_q;
   reg [15:0] sp_prev_q;
   reg [15:0] eco_cnt_q;
   reg [15:0] trim_q;
   reg div_start_q;
   reg [31:0] div_dvd_q;
   reg [31:0] div_dvs_q;
   wire div_done;
   wire [31:0] div_quot;
   wire [31:0] div_rem;

   wire run = ctrl_q[`SSRV_CTRL_RUN];
   wire qstop = ctrl_q[`SSRV_CTRL_QSTOP];
   wire ext_ramp = ctrl_q[`SSRV_CTRL_EXT];
   wire [2:0] mode = ctrl_q[`SSRV_CTRL_MODE_HI:`SSRV_CTRL_MODE_LO];
   wire [7:0] pole_pairs = ctrl_q[`SSRV_CTRL_PP_HI:`SSRV_CTRL_PP_LO];
   wire mode_fcc = (mode == 3'd1) || (mode == 3'd6);
   wire mode_eco = (mode == 3'd4) || (mode == 3'd7);
   wire mode_precise = (mode == 3'd5) || (mode == 3'd6);

   // Target: clamp magnitude, keep requested sign, zero when stopped
   reg [15:0] sp_mag;
   reg [15:0] lim;
   reg [15:0] target;
   always @*
   begin
      sp_mag = mag(setpoint_q);
      lim = (sp_mag > max_q) ? max_q : sp_mag;
      if (lim < min_q)
         lim = min_q;
      if (run && !qstop)
         target = setpoint_q[15] ? (16'h0000 - lim) : lim;
      else
         target = 16'h0000;
   end

   // Magnitude grows when moving away from zero
   wire tgt_above = $signed(target) > $signed(ramp_q);
   wire accel = tgt_above ? !ramp_q[15] : (ramp_q[15] || ramp_q == 16'h0000);
   wire [16:0] rnd_sum = {1'b0, rnd_init_q} + {1'b0, rnd_final_q};
   reg [16:0] dur_sel;
   always @*
   begin
      if (qstop)
         dur_sel = {1'b0, qstop_q};
      else
         dur_sel = {1'b0, accel ? up_q : down_q};
      if (ext_ramp && !qstop)
         dur_sel = dur_sel + rnd_sum;
   end

   // Step this sample: quotient plus carry of the remainder
   wire [17:0] frac_sum = {1'b0, frac_q} + {1'b0, div_rem[16:0]};
   wire carry = (dur_q != 17'h00000) && (frac_sum >= {1'b0, dur_q});
   wire [16:0] step = div_quot[16:0] + {16'h0000, carry};
   wire [16:0] gap = tgt_above ? ({target[15], target} - {ramp_q[15], ramp_q})
                               : ({ramp_q[15], ramp_q} - {target[15], target});
   wire land = (gap <= step);
   wire [15:0] ramp_next = land ? target
                         : (tgt_above ? ramp_q + step[15:0] : ramp_q - step[15:0]);

   // Characteristic from relative speed, 1024 = max speed
   wire [15:0] rel = (div_quot[15:0] > 16'h0400) ? 16'h0400 : div_quot[15:0];
   wire [31:0] rel_sq = rel * rel;
   wire [31:0] rel_usr = rel * vf_gain_q;
   wire [31:0] fcc_add = motor_current_i * stator_r_q;
   reg [17:0] v_base;
   reg [17:0] v_out;
   reg [25:0] v_eco;
   always @*
   begin
      case (mode)
         3'd2, 3'd7: v_base = {2'b00, rel_sq[25:10]};
         3'd3: v_base = {2'b00, rel_usr[23:8]};
         default: v_base = {2'b00, rel};
      endcase
      v_out = v_base;
      if (mode_fcc)
         v_out = v_out + {2'b00, fcc_add[25:`SSRV_FCC_SHIFT]};
      v_eco = v_out * `SSRV_ECO_LEVEL;
      if (mode_eco && eco_active_o)
         v_out = v_eco[25:8];
      if (mode_precise)
         v_out = (v_out > {2'b00, trim_q}) ? v_out - {2'b00, trim_q} : 18'h00000;
      if (v_out > 18'h0FFFF)
         v_out = 18'h0FFFF;
   end

   // Frequency in 0.1 Hz: n * pp / 60 * 10
   wire [23:0] n_pp = mag(ramp_q) * pole_pairs;
   wire [23:0] nmax_pp = max_q * pole_pairs;
   wire [23:0] f_now = n_pp / 24'd6;
   wire [23:0] f_max = nmax_pp / 24'd6;

   // Setpoint change beyond the tolerance band
   wire [16:0] sp_delta = {setpoint_q[15], setpoint_q} - {sp_prev_q[15], sp_prev_q};
   wire [16:0] sp_dmag = sp_delta[16] ? (17'h00000 - sp_delta) : sp_delta;
   wire sp_changed = sp_dmag > {1'b0, tol_q};
   wire dc_bad = dc_link_high_i || dc_link_low_i;

   wire [7:0] adr = {wb_adr_i[7:2], 2'b00};
   wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wb_wr = wb_req && wb_we_i;
   wire over = mag(actual_speed_i) > max_q;
   wire at_target = (ramp_q == target);
   wire [15:0] status = {10'h000, slip_comp_en_o, current_limit_i, qstop, eco_active_o,
                         at_target, overspeed_o};

   ssrv_div #(
      .W(32)
   ) u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(div_start_q),
      .dividend_i(div_dvd_q),
      .divisor_i(div_dvs_q),
      .done_o(div_done),
      .quot_o(div_quot),
      .rem_o(div_rem)
   );

   // Register writes and bus answer
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= `SSRV_RST_CTRL;
         setpoint_q <= 16'h0000;
         min_q <= `SSRV_RST_MIN_SPEED;
         max_q <= `SSRV_RST_MAX_SPEED;
         up_q <= `SSRV_RST_RAMP;
         down_q <= `SSRV_RST_RAMP;
         qstop_q <= `SSRV_RST_QSTOP;
         rnd_init_q <= 16'h0000;
         rnd_final_q <= 16'h0000;
         stator_r_q <= 16'h0000;
         slip_gain_q <= `SSRV_RST_SLIP_GAIN;
         tol_q <= `SSRV_RST_RAMP_TOL;
         vf_gain_q <= `SSRV_RST_VF_GAIN;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         overspeed_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= wb_req;
         if (wb_wr)
         begin
            case (adr)
               `SSRV_OFF_CTRL: ctrl_q <= merge16(ctrl_q, wb_dat_i[15:0], wb_sel_i[1:0]);
               `SSRV_OFF_SETPOINT:
                  setpoint_q <= merge16(setpoint_q, wb_dat_i[15:0], wb_sel_i[1:0]);
               `SSRV_OFF_MIN_SPEED: min_q <= merge16(min_q, wb_dat_i[15:0], wb_sel_i[1:0]);
               `SSRV_OFF_MAX_SPEED: max_q <= merge16(max_q, wb_dat_i[15:0], wb_sel_i[1:0]);
               `SSRV_OFF_RAMP_UP: up_q <= merge16(up_q, wb_dat_i[15:0], wb_sel_i[1:0]);
               `SSRV_OFF_RAMP_DOWN: down_q <= merge16(down_q, wb_dat_i[15:0], wb_sel_i[1:0]);
               `SSRV_OFF_QSTOP: qstop_q <= merge16(qstop_q, wb_dat_i[15:0], wb_sel_i[1:0]);
               `SSRV_OFF_ROUNDING:
               begin
                  rnd_init_q <= merge16(rnd_init_q, wb_dat_i[15:0], wb_sel_i[1:0]);
                  rnd_final_q <= merge16(rnd_final_q, wb_dat_i[31:16], wb_sel_i[3:2]);
               end
               `SSRV_OFF_STATOR_R:
                  stator_r_q <= merge16(stator_r_q, wb_dat_i[15:0], wb_sel_i[1:0]);
               `SSRV_OFF_SLIP_GAIN:
                  slip_gain_q <= merge16(slip_gain_q, wb_dat_i[15:0], wb_sel_i[1:0]);
               `SSRV_OFF_RAMP_TOL: tol_q <= merge16(tol_q, wb_dat_i[15:0], wb_sel_i[1:0]);
               `SSRV_OFF_VF_GAIN:
                  vf_gain_q <= merge16(vf_gain_q, wb_dat_i[15:0], wb_sel_i[1:0]);
               default: ;
            endcase
         end
         // New overspeed wins over a clear in the same cycle
         if (over)
            overspeed_o <= 1'b1;
         else if (wb_wr && adr == `SSRV_OFF_STATUS && wb_sel_i[0]
                  && wb_dat_i[`SSRV_ST_OVERSPEED])
            overspeed_o <= 1'b0;
         if (wb_req && !wb_we_i)
         begin
            case (adr)
               `SSRV_OFF_CTRL: wb_dat_o <= {16'h0000, ctrl_q};
               `SSRV_OFF_SETPOINT: wb_dat_o <= {16'h0000, setpoint_q};
               `SSRV_OFF_MIN_SPEED: wb_dat_o <= {16'h0000, min_q};
               `SSRV_OFF_MAX_SPEED: wb_dat_o <= {16'h0000, max_q};
               `SSRV_OFF_RAMP_UP: wb_dat_o <= {16'h0000, up_q};
               `SSRV_OFF_RAMP_DOWN: wb_dat_o <= {16'h0000, down_q};
               `SSRV_OFF_QSTOP: wb_dat_o <= {16'h0000, qstop_q};
               `SSRV_OFF_ROUNDING: wb_dat_o <= {rnd_final_q, rnd_init_q};
               `SSRV_OFF_STATOR_R: wb_dat_o <= {16'h0000, stator_r_q};
               `SSRV_OFF_SLIP_GAIN: wb_dat_o <= {16'h0000, slip_gain_q};
               `SSRV_OFF_RAMP_TOL: wb_dat_o <= {16'h0000, tol_q};
               `SSRV_OFF_STATUS: wb_dat_o <= {16'h0000, status};
               `SSRV_OFF_RAMP_OUT: wb_dat_o <= {16'h0000, ramp_q};
               `SSRV_OFF_FREQ: wb_dat_o <= {16'h0000, freq_o};
               `SSRV_OFF_FMAX: wb_dat_o <= {16'h0000, fmax_q};
               `SSRV_OFF_VOLT: wb_dat_o <= {16'h0000, volt_o};
               `SSRV_OFF_VF_GAIN: wb_dat_o <= {16'h0000, vf_gain_q};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   // Sample sequencer: step division, ramp update, relative speed division
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= S_IDLE;
         tick_cnt_q <= 16'h0000;
         ramp_q <= 16'h0000;
         frac_q <= 17'h00000;
         dur_q <= 17'h00000;
         div_start_q <= 1'b0;
         div_dvd_q <= 32'h00000000;
         div_dvs_q <= 32'h00000001;
         speed_ref_o <= 16'h0000;
         freq_o <= 16'h0000;
         fmax_q <= 16'h0000;
         volt_o <= 16'h0000;
         slip_comp_en_o <= 1'b0;
         eco_active_o <= 1'b0;
         eco_cnt_q <= 16'h0000;
         sp_prev_q <= 16'h0000;
         trim_q <= 16'h0000;
      end
      else
      begin
         div_start_q <= 1'b0;
         // Sample period far exceeds the two 32-clock divisions
         tick_cnt_q <= (tick_cnt_q == SAMPLE_CYCLES[15:0] - 16'h0001) ? 16'h0000
                       : tick_cnt_q + 16'h0001;
         case (state_q)
            S_IDLE:
            begin
               if (tick_cnt_q == 16'h0000)
               begin
                  // Zero duration steps by the full max speed per sample
                  div_dvd_q <= {16'h0000, max_q};
                  div_dvs_q <= (dur_sel == 17'h00000) ? 32'h00000001 : {15'h0000, dur_sel};
                  if (dur_sel != dur_q)
                     frac_q <= 17'h00000;
                  dur_q <= dur_sel;
                  div_start_q <= 1'b1;
                  state_q <= S_STEP;
               end
            end
            S_STEP:
            begin
               if (div_done)
               begin
                  ramp_q <= ramp_next;
                  speed_ref_o <= ramp_next;
                  if (land)
                     frac_q <= 17'h00000;
                  else if (carry)
                     frac_q <= frac_sum[16:0] - dur_q;
                  else
                     frac_q <= frac_sum[16:0];
                  div_dvd_q <= {6'h00, mag(ramp_next), 10'h000};
                  div_dvs_q <= (max_q == 16'h0000) ? 32'h00000001 : {16'h0000, max_q};
                  div_start_q <= 1'b1;
                  state_q <= S_REL;
               end
            end
            S_REL:
            begin
               if (div_done)
               begin
                  volt_o <= v_out[15:0];
                  freq_o <= f_now[15:0];
                  fmax_q <= f_max[15:0];
                  slip_comp_en_o <= !mode_precise && (slip_gain_q != 16'h0000);
                  // Precise modes trade voltage for held speed at current limit
                  if (mode_precise && current_limit_i)
                     trim_q <= trim_q + `SSRV_TRIM_STEP;
                  else if (trim_q > `SSRV_TRIM_STEP)
                     trim_q <= trim_q - `SSRV_TRIM_STEP;
                  else
                     trim_q <= 16'h0000;
                  sp_prev_q <= setpoint_q;
                  if (!mode_eco || sp_changed || dc_bad || !at_target)
                  begin
                     eco_cnt_q <= 16'h0000;
                     eco_active_o <= 1'b0;
                  end
                  else if (eco_cnt_q >= ECO_SAMPLES[15:0])
                     eco_active_o <= 1'b1;
                  else
                     eco_cnt_q <= eco_cnt_q + 16'h0001;
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule // ssrv_top
`default_nettype wire

// ==== ssrv_top_checker.sv ====
// Concurrent checks on the ports of the setpoint ramp block
`timescale 1ns/1ps
`default_nettype none
module ssrv_top_checker #(
   parameter SAMPLE_CYCLES = 100
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic [7:0] wb_adr_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Drive side
   input wire logic dc_link_high_i,
   input wire logic dc_link_low_i,
   input wire logic [15:0] speed_ref_o,
   input wire logic [15:0] freq_o,
   input wire logic eco_active_o,
   input wire logic overspeed_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic [31:0] bad_q;
   logic [31:0] zero_q;
   logic [31:0] still_q;
   logic [15:0] ref_q;
   // Saturating counters stand in for long repetitions
   always @(posedge clk_i)
   begin
      bad_q <= (rst_i || !(dc_link_high_i || dc_link_low_i)) ? 0 : bad_q + (bad_q < 32'hFFFF);
      zero_q <= (rst_i || speed_ref_o != 16'h0000) ? 0 : zero_q + (zero_q < 32'hFFFF);
      still_q <= (rst_i || speed_ref_o != ref_q) ? 0 : still_q + (still_q < 32'hFFFF);
      ref_q <= speed_ref_o;
   end
   sequence bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   ack_timing_a: assert property (bus_req |=> ack_once) else $error("ack timing wrong");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   upper_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] != 6'h07
      |-> wb_dat_o[31:16] == 16'h0000) else $error("upper read bits set");
   unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h44
      |-> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
   over_sticky_a: assert property (overspeed_o && !(wb_cyc_i && wb_we_i) |=> overspeed_o)
      else $error("overspeed fault dropped");
   ref_once_a: assert property ($changed(speed_ref_o) |=> $stable(speed_ref_o)[*8])
      else $error("ramp output changed twice");
   eco_cancel_a: assert property (bad_q >= 2 * SAMPLE_CYCLES |-> !eco_active_o)
      else $error("eco kept with DC-link out of band");
   eco_steady_a: assert property ($rose(eco_active_o) |-> still_q >= 3 * SAMPLE_CYCLES)
      else $error("eco before steady state");
   stop_freq_a: assert property (zero_q >= SAMPLE_CYCLES |-> freq_o == 16'h0000)
      else $error("frequency at standstill");
endmodule // ssrv_top_checker
`default_nettype wire

// ==== ssrv_motor_model.sv ====
// Motor model on the far side of the block
`timescale 1ns/1ps
`default_nettype none
module ssrv_motor_model (
   // Clock
   input wire logic clk_i,
   // From the block and bench
   input wire logic [15:0] speed_ref_i,
   input wire logic [15:0] slip_i,
   // To the block
   output var logic [15:0] actual_speed_o = 16'h0000,
   output var logic [15:0] current_o = 16'h0000
);
   // Shaft follows the reference plus a bench-chosen slip
   always @(posedge clk_i)
   begin
      actual_speed_o <= speed_ref_i + slip_i;
      current_o <= 16'h0100;
   end
endmodule // ssrv_motor_model
`default_nettype wire

// ==== tb_speed_setpoint_ramp_vf_select.sv ====
// Self-checking bench for the setpoint ramp block
`timescale 1ns/1ps
`default_nettype none
module tb_speed_setpoint_ramp_vf_select;
   localparam int SC = 100;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_we_i = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [15:0] act, cur, slip_q = 16'h0000, speed_ref_o, freq_o, volt_o;
   logic dc_high = 1'b0, dc_low = 1'b0, ilim = 1'b0;
   logic slip_comp_en_o, eco_active_o, overspeed_o;
   logic [31:0] rd;
   int failures = 0;
   int checked = 0;
   int q[$] = '{-50, 20, 5000, -5000};
   int v[8];
   int sp;
   always #50 clk_i = ~clk_i;
   ssrv_motor_model motor (.clk_i(clk_i), .speed_ref_i(speed_ref_o), .slip_i(slip_q),
      .actual_speed_o(act), .current_o(cur));
   ssrv_top #(.SAMPLE_CYCLES(SC), .ECO_SAMPLES(5)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .actual_speed_i(act), .motor_current_i(cur), .current_limit_i(ilim),
      .dc_link_high_i(dc_high), .dc_link_low_i(dc_low), .speed_ref_o(speed_ref_o),
      .freq_o(freq_o), .volt_o(volt_o), .slip_comp_en_o(slip_comp_en_o),
      .eco_active_o(eco_active_o), .overspeed_o(overspeed_o));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w);
      int n;
      @(posedge clk_i);
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_we_i <= w;
      wb_sel_i <= 4'hF;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 100);
      chk(n < 100, 1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic ctl(input logic run, input logic qs, input logic ext, input logic [2:0] m);
      wb(8'h00, {16'h0000, 8'h02, 1'b0, m, 1'b0, ext, qs, run}, 1'b1);
   endtask
   task automatic samples(input int k);
      repeat (k * SC) @(posedge clk_i);
   endtask
   // Time to reach a target, in samples, with one sample of slack for latency
   task automatic ramp_time(input logic [15:0] tgt, input int e);
      int n;
      n = 0;
      while (speed_ref_o !== tgt && n < 40 * SC)
      begin
         @(posedge clk_i);
         n++;
      end
      chk((n + SC / 2) / SC >= e - 1 && (n + SC / 2) / SC <= e + 1, 1);
   endtask
   function automatic logic [15:0] exp_ref(input int s, input int mn, input int mx);
      int m;
      m = (s < 0) ? -s : s;
      if (m > mx) m = mx;
      if (m < mn) m = mn;
      return 16'((s < 0) ? -m : m);
   endfunction
   task automatic final_report;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #(70000 * 100);
      failures++;
      final_report;
   end
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      void'($urandom(3));
      wb(8'h0C, 0, 0);
      chk(rd, 32'h000005DC);
      wb(8'h00, 0, 0);
      chk(rd, 32'h00000200);
      wb(8'hF0, 32'hFFFF, 1);
      wb(8'hF0, 0, 0);
      chk(rd, 0);
      wb(8'h08, 100, 1);
      wb(8'h0C, 1000, 1);
      wb(8'h10, 10, 1);
      wb(8'h14, 20, 1);
      wb(8'h18, 5, 1);
      wb(8'h1C, {16'd5, 16'd5}, 1);
      wb(8'h20, 16'h0400, 1);
      wb(8'h24, 100, 1);
      wb(8'h04, 1000, 1);
      ctl(1, 0, 0, 0);
      ramp_time(1000, 10);
      samples(1);
      chk(freq_o, 333);
      wb(8'h38, 0, 0);
      chk(rd, 333);
      ctl(0, 0, 0, 0);
      ramp_time(0, 20);
      ctl(1, 0, 1, 0);
      ramp_time(1000, 20);
      ctl(1, 1, 1, 0);
      ramp_time(0, 5);
      ctl(1, 0, 0, 0);
      repeat (4) q.push_back(int'($urandom_range(6000)) - 3000);
      foreach (q[i])
      begin
         wb(8'h04, 32'(q[i]) & 32'hFFFF, 1);
         samples(40);
         chk(speed_ref_o, exp_ref(q[i], 100, 1000));
      end
      wb(8'h04, 1000, 1);
      samples(40);
      slip_q <= 16'd100;
      samples(3);
      chk(overspeed_o, 1);
      slip_q <= 16'd0;
      samples(2);
      wb(8'h2C, 0, 0);
      chk(rd[0], 1);
      wb(8'h2C, 1, 1);
      samples(1);
      chk(overspeed_o, 0);
      for (int m = 0; m < 8; m++)
      begin
         ctl(1, 0, 0, 3'(m));
         samples(12);
         v[m] = volt_o;
         chk(eco_active_o, m == 4 || m == 7);
         if (m == 5 || m == 6)
            chk(slip_comp_en_o, 0);
         else
            chk(slip_comp_en_o, 1);
      end
      dc_high <= 1'b1;
      samples(3);
      chk(eco_active_o, 0);
      dc_high <= 1'b0;
      // Eco must come back once the link is in band, then drop on undervoltage
      samples(12);
      chk(eco_active_o, 1);
      dc_low <= 1'b1;
      samples(3);
      chk(eco_active_o, 0);
      dc_low <= 1'b0;
      ctl(1, 0, 0, 3'd5);
      ilim <= 1'b1;
      samples(4);
      chk(volt_o < v[5], 1);
      chk(speed_ref_o, 1000);
      ilim <= 1'b0;
      chk(v[1] > v[0], 1);
      chk(v[4] < v[0], 1);
      final_report;
   end
endmodule // tb_speed_setpoint_ramp_vf_select
bind ssrv_top ssrv_top_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk_i (.clk_i(clk_i),
   .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .dc_link_high_i(dc_link_high_i), .dc_link_low_i(dc_link_low_i),
   .speed_ref_o(speed_ref_o), .freq_o(freq_o), .eco_active_o(eco_active_o),
   .overspeed_o(overspeed_o));
`default_nettype wire
